// ===== cihc_pkg.sv
// Shared constants and types of the interrupt and bus-hold control block
package cihc_pkg;

   // ------------------------------------------------------------
   // Vectors and interrupt modes
   // ------------------------------------------------------------
   localparam logic [15:0] NMI_VECTOR   = 16'h0066;
   localparam logic [15:0] MODE1_VECTOR = 16'h0038;
   localparam logic [15:0] MODE0_VECTOR = 16'h0000;
   localparam logic [1:0]  IRQ_MODE0    = 2'h0;
   localparam logic [1:0]  IRQ_MODE1    = 2'h1;
   localparam logic [1:0]  IRQ_MODE2    = 2'h2;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int          CLK_PERIOD_NS = 4;
   localparam int          ACK_TIME_NS   = 16;
   localparam int          ACK_CYCLES    = (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0]  ACK_LAST      = 3'(ACK_CYCLES - 1);

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [2:0]  SYNC_RESET    = 3'h7;
   localparam logic [15:0] ADDR_RESET    = 16'h0000;
   localparam logic [7:0]  DATA_RESET    = 8'h00;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_HOLD = 3'h2,
      ST_ACK  = 3'h4
   } cihc_state_t;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] f;
   } cihc_sync_t;

   typedef struct packed {
      cihc_state_t st;
      logic [2:0]  cnt;
      logic        nmi_prev;
      logic        nmi_pend;
      logic        grant_n;
      logic        stall;
      logic        svc;
      logic        svc_nmi;
      logic [15:0] vec;
      logic [7:0]  ackd;
      logic [15:0] addr;
      logic [7:0]  dout;
      logic        bus_oe;
      logic        dout_oe;
      logic        memory_cycle_n_n;
      logic        io_n;
      logic        rd_n;
      logic        wr_n;
      logic        m1_n;
   } cihc_regs_t;

endpackage : cihc_pkg

// ===== cihc_sync_if.sv
// Filtered request levels passed from the pin synchroniser to the control core
`timescale 1ns/1ns
interface cihc_sync_if;
   logic irq_n;
   logic nmi_n;
   logic hold_n;
   modport drv (output irq_n, output nmi_n, output hold_n);
   modport mon (input irq_n, input nmi_n, input hold_n);
endinterface : cihc_sync_if

// ===== cihc_pin_sync.sv
// Three-stage synchroniser with agreement filter for the request pins
`timescale 1ns/1ns
module cihc_pin_sync (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] raw,
   cihc_sync_if.drv        sync
);

   cihc_pkg::cihc_sync_t r_r;
   cihc_pkg::cihc_sync_t r_nxt;
   logic [2:0]           upd;

   // ------------------------------------------------------------
   // Level follows once stages two and three agree
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_bit
         assign upd[gi] = (r_r.s2[gi] == r_r.s3[gi]) ? r_r.s2[gi] : r_r.f[gi];
      end
   endgenerate

   always_comb
   begin
      r_nxt    = r_r;
      r_nxt.s1 = raw;
      r_nxt.s2 = r_r.s1;
      r_nxt.s3 = r_r.s2;
      r_nxt.f  = upd;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r_r <= {cihc_pkg::SYNC_RESET, cihc_pkg::SYNC_RESET,
                 cihc_pkg::SYNC_RESET, cihc_pkg::SYNC_RESET};
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   assign sync.irq_n  = r_r.f[0];
   assign sync.nmi_n  = r_r.f[1];
   assign sync.hold_n = r_r.f[2];

endmodule : cihc_pin_sync

// ===== cihc_core.sv
// Interrupt ranking, acknowledge sequencing and bus-hold control
`timescale 1ns/1ns
module cihc_core (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   input  wire logic        MASKABLE_IRQ_N,
   input  wire logic        NMI_N,
   input  wire logic        BUS_HOLD_REQUEST_N,
   input  wire logic        IRQ_ENABLE,
   input  wire logic [1:0]  IRQ_MODE,
   input  wire logic [7:0]  IRQ_PAGE,
   input  wire logic        INSTR_DONE,
   input  wire logic        MCYCLE_END,
   input  wire logic [15:0] CORE_ADDR,
   input  wire logic [7:0]  CORE_DOUT,
   input  wire logic        CORE_DOUT_OE,
   input  wire logic        CORE_MEMORY_CYCLE_N_N,
   input  wire logic        CORE_IO_CYCLE_N_N,
   input  wire logic        CORE_RD_N,
   input  wire logic        CORE_WR_N,
   input  wire logic        CORE_M1_N,
   input  wire logic [7:0]  DATA_I,
   output logic [15:0]      ADDR_O,
   output logic             ADDR_OE,
   output logic [7:0]       DATA_O,
   output logic             DATA_OE,
   output logic             MEMORY_CYCLE_N,
   output logic             IO_CYCLE_N,
   output logic             READ_STROBE_N,
   output logic             WRITE_STROBE_N,
   output logic             STROBE_OE,
   output logic             OPCODE_FETCH_CYCLE_N,
   output logic             BUS_HOLD_GRANT_N,
   output logic             CPU_RESET_N,
   output logic             CORE_STALL,
   output logic             SVC_REQ,
   output logic             SVC_NMI,
   output logic [15:0]      SVC_VECTOR,
   output logic [7:0]       SVC_DATA
);

   logic [1:0]              rst_q;
   logic                    rst_n;
   cihc_pkg::cihc_regs_t    r_r;
   cihc_pkg::cihc_regs_t    r_nxt;
   logic                    nmi_edge;
   logic                    take_nmi;
   logic                    hold_on;
   cihc_sync_if             sync ();

   // ------------------------------------------------------------
   // Reset release and pin synchronisation
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_q <= 2'h0;
      end
      else
      begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   cihc_pin_sync u_sync (
      .clk  (CLK_SYS),
      .rst_n(rst_n),
      .raw  ({BUS_HOLD_REQUEST_N, NMI_N, MASKABLE_IRQ_N}),
      .sync (sync.drv)
   );

   assign hold_on  = !sync.hold_n;
   assign nmi_edge = r_r.nmi_prev & !sync.nmi_n;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      r_nxt          = r_r;
      take_nmi       = 1'b0;
      r_nxt.svc      = 1'b0;
      r_nxt.nmi_prev = sync.nmi_n;
      case (r_r.st)
         cihc_pkg::ST_IDLE:
         begin
            if (hold_on && MCYCLE_END)
            begin
               r_nxt.st      = cihc_pkg::ST_HOLD;
               r_nxt.grant_n = 1'b0;
               r_nxt.stall   = 1'b1;
            end
            else if (INSTR_DONE && !hold_on && r_r.nmi_pend)
            begin
               take_nmi      = 1'b1;
               r_nxt.svc     = 1'b1;
               r_nxt.svc_nmi = 1'b1;
               r_nxt.vec     = cihc_pkg::NMI_VECTOR;
            end
            else if (INSTR_DONE && !hold_on && !sync.irq_n && IRQ_ENABLE)
            begin
               r_nxt.st    = cihc_pkg::ST_ACK;
               r_nxt.cnt   = 3'h0;
               r_nxt.stall = 1'b1;
            end
         end
         cihc_pkg::ST_HOLD:
         begin
            if (!hold_on)
            begin
               r_nxt.st      = cihc_pkg::ST_IDLE;
               r_nxt.grant_n = 1'b1;
               r_nxt.stall   = 1'b0;
            end
         end
         cihc_pkg::ST_ACK:
         begin
            r_nxt.cnt = r_r.cnt + 3'h1;
            if (r_r.cnt == cihc_pkg::ACK_LAST)
            begin
               r_nxt.st      = cihc_pkg::ST_IDLE;
               r_nxt.stall   = 1'b0;
               r_nxt.svc     = 1'b1;
               r_nxt.svc_nmi = 1'b0;
               r_nxt.ackd    = DATA_I;
               case (IRQ_MODE)
                  cihc_pkg::IRQ_MODE1: r_nxt.vec = cihc_pkg::MODE1_VECTOR;
                  cihc_pkg::IRQ_MODE2: r_nxt.vec = {IRQ_PAGE, DATA_I};
                  default:             r_nxt.vec = cihc_pkg::MODE0_VECTOR;
               endcase
            end
         end
         default:
         begin
            r_nxt.st      = cihc_pkg::ST_IDLE;
            r_nxt.grant_n = 1'b1;
            r_nxt.stall   = 1'b0;
         end
      endcase
      // Set wins over the clear
      r_nxt.nmi_pend = nmi_edge | (r_r.nmi_pend & !take_nmi);
      // Pin stage follows the core unless overridden
      r_nxt.addr    = CORE_ADDR;
      r_nxt.dout    = CORE_DOUT;
      r_nxt.bus_oe  = (r_nxt.st != cihc_pkg::ST_HOLD);
      r_nxt.dout_oe = r_nxt.bus_oe & CORE_DOUT_OE;
      r_nxt.memory_cycle_n_n  = CORE_MEMORY_CYCLE_N_N;
      r_nxt.io_n    = CORE_IO_CYCLE_N_N;
      r_nxt.rd_n    = CORE_RD_N;
      r_nxt.wr_n    = CORE_WR_N;
      r_nxt.m1_n    = CORE_M1_N;
      if (r_nxt.st == cihc_pkg::ST_ACK)
      begin
         r_nxt.io_n    = 1'b0;
         r_nxt.m1_n    = 1'b0;
         r_nxt.memory_cycle_n_n  = 1'b1;
         r_nxt.rd_n    = 1'b1;
         r_nxt.wr_n    = 1'b1;
         r_nxt.dout_oe = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r_r          <= '0;
         r_r.st       <= cihc_pkg::ST_IDLE;
         r_r.nmi_prev <= 1'b1;
         r_r.grant_n  <= 1'b1;
         r_r.stall    <= 1'b1;
         r_r.vec      <= cihc_pkg::ADDR_RESET;
         r_r.ackd     <= cihc_pkg::DATA_RESET;
         r_r.addr     <= cihc_pkg::ADDR_RESET;
         r_r.dout     <= cihc_pkg::DATA_RESET;
         r_r.memory_cycle_n_n   <= 1'b1;
         r_r.io_n     <= 1'b1;
         r_r.rd_n     <= 1'b1;
         r_r.wr_n     <= 1'b1;
         r_r.m1_n     <= 1'b1;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign ADDR_O               = r_r.addr;
   assign ADDR_OE              = r_r.bus_oe;
   assign DATA_O               = r_r.dout;
   assign DATA_OE              = r_r.dout_oe;
   assign MEMORY_CYCLE_N       = r_r.memory_cycle_n_n;
   assign IO_CYCLE_N           = r_r.io_n;
   assign READ_STROBE_N        = r_r.rd_n;
   assign WRITE_STROBE_N       = r_r.wr_n;
   assign STROBE_OE            = r_r.bus_oe;
   assign OPCODE_FETCH_CYCLE_N = r_r.m1_n;
   assign BUS_HOLD_GRANT_N     = r_r.grant_n;
   assign CPU_RESET_N          = rst_q[1];
   assign CORE_STALL           = r_r.stall;
   assign SVC_REQ              = r_r.svc;
   assign SVC_NMI              = r_r.svc_nmi;
   assign SVC_VECTOR           = r_r.vec;
   assign SVC_DATA             = r_r.ackd;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!rst_n);

   a_irq_accept: assert property ((r_r.st == cihc_pkg::ST_IDLE) && INSTR_DONE && !hold_on
      && !r_r.nmi_pend && !sync.irq_n && IRQ_ENABLE |=> !IO_CYCLE_N && CORE_STALL)
      else $error("maskable request not accepted");
   a_nmi_vector: assert property (SVC_REQ && SVC_NMI |-> SVC_VECTOR == cihc_pkg::NMI_VECTOR)
      else $error("wrong non-maskable vector");
   a_nmi_first: assert property ((r_r.st == cihc_pkg::ST_IDLE) && INSTR_DONE && !hold_on
      && r_r.nmi_pend |=> SVC_REQ && SVC_NMI && IO_CYCLE_N)
      else $error("non-maskable not serviced first");
   a_reset_hold: assert property (disable iff (1'b0) !RST_N |=> !CPU_RESET_N && CORE_STALL)
      else $error("core not held in reset");
   a_bus_float: assert property (!BUS_HOLD_GRANT_N |-> !ADDR_OE && !DATA_OE && !STROBE_OE)
      else $error("bus driven during hold");
   a_hold_first: assert property ((r_r.st == cihc_pkg::ST_IDLE) && MCYCLE_END && hold_on
      |=> !BUS_HOLD_GRANT_N && !SVC_REQ)
      else $error("hold not honoured first");
   a_grant_exact: assert property ($past(rst_n) |-> BUS_HOLD_GRANT_N == ADDR_OE)
      else $error("grant and float disagree");
   a_mode1_vec: assert property (SVC_REQ && !SVC_NMI && $past(IRQ_MODE) == cihc_pkg::IRQ_MODE1
      |-> SVC_VECTOR == cihc_pkg::MODE1_VECTOR)
      else $error("wrong mode 1 vector");
   a_hold_no_irq: assert property (!BUS_HOLD_GRANT_N |=> !SVC_REQ && IO_CYCLE_N)
      else $error("interrupt accepted during hold");
   a_ack_cycle: assert property (!IO_CYCLE_N && !OPCODE_FETCH_CYCLE_N |-> ##[1:4] SVC_REQ)
      else $error("acknowledge did not complete");
   a_mode2_vec: assert property (SVC_REQ && !SVC_NMI && $past(IRQ_MODE) == cihc_pkg::IRQ_MODE2
      |-> SVC_VECTOR == {$past(IRQ_PAGE), SVC_DATA})
      else $error("wrong mode 2 address");
   a_hold_release: assert property (!BUS_HOLD_GRANT_N && !hold_on |=> BUS_HOLD_GRANT_N)
      else $error("grant not released");

   c_hold: cover property (!BUS_HOLD_GRANT_N ##1 BUS_HOLD_GRANT_N);
   c_nmi: cover property (SVC_REQ && SVC_NMI);
   c_mode2: cover property (SVC_REQ && !SVC_NMI && $past(IRQ_MODE) == cihc_pkg::IRQ_MODE2);

endmodule : cihc_core

// ===== cihc_far_model.sv
// Far-side model: interrupting peripheral and external bus master
`timescale 1ns/1ns
module cihc_far_model (
   input  wire logic       clk,
   input  wire logic       want_irq,
   input  wire logic       want_nmi,
   input  wire logic       want_hold,
   input  wire logic [7:0] vec,
   input  wire logic       io_cycle_n,
   input  wire logic       fetch_n,
   output logic            irq_n,
   output logic            nmi_n,
   output logic            hold_n,
   output logic [7:0]      data_o
);
   initial
   begin
      irq_n  = 1'b1;
      nmi_n  = 1'b1;
      hold_n = 1'b1;
      data_o = 8'h5a;
   end

   // ------------------------------------------------------------
   // Pin drive and acknowledge response
   // ------------------------------------------------------------
   always @(posedge clk)
   begin
      irq_n  <= ~want_irq;
      nmi_n  <= ~want_nmi;
      hold_n <= ~want_hold;
      if (!io_cycle_n && !fetch_n)
         data_o <= vec;
      else
         data_o <= ~data_o;
   end
endmodule : cihc_far_model

// ===== tb_top.sv
// Self-checking testbench of the interrupt and bus-hold control block
`timescale 1ns/1ns
module tb_top;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        want_irq = 1'b0;
   logic        want_nmi = 1'b0;
   logic        want_hold = 1'b0;
   logic [7:0]  vb = 8'ha0;
   logic        irq_n, nmi_n, hold_n;
   logic [7:0]  data_i;
   logic        irq_enable = 1'b0;
   logic [1:0]  irq_mode = 2'h0;
   logic [7:0]  irq_page = 8'h7c;
   logic        instr_done = 1'b0;
   logic        mcycle_end = 1'b0;
   logic [15:0] core_addr = 16'h1234;
   logic [7:0]  core_dout = 8'h5c;
   logic        core_dout_oe = 1'b1;
   logic        core_memory_cycle_n_n = 1'b0;
   logic        core_io_cycle_n_n = 1'b1;
   logic        core_rd_n = 1'b0;
   logic        core_wr_n = 1'b1;
   logic        core_m1_n = 1'b1;
   logic [15:0] addr_o, svc_vector;
   logic [7:0]  data_o, svc_data;
   logic        addr_oe, data_oe, mem_n, io_n, rd_n, wr_n, strobe_oe, m1_n;
   logic        grant_n, cpu_reset_n, core_stall, svc_req, svc_nmi;
   int          fail_count = 0;
   int          n_tests = 0;

   always #2 clk_sys = ~clk_sys;

   cihc_far_model far_u (.clk(clk_sys), .want_irq(want_irq), .want_nmi(want_nmi),
      .want_hold(want_hold), .vec(vb), .io_cycle_n(io_n), .fetch_n(m1_n),
      .irq_n(irq_n), .nmi_n(nmi_n), .hold_n(hold_n), .data_o(data_i));

   cihc_core dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .MASKABLE_IRQ_N(irq_n),
      .NMI_N(nmi_n), .BUS_HOLD_REQUEST_N(hold_n), .IRQ_ENABLE(irq_enable),
      .IRQ_MODE(irq_mode), .IRQ_PAGE(irq_page), .INSTR_DONE(instr_done),
      .MCYCLE_END(mcycle_end), .CORE_ADDR(core_addr), .CORE_DOUT(core_dout),
      .CORE_DOUT_OE(core_dout_oe), .CORE_MEMORY_CYCLE_N_N(core_memory_cycle_n_n), .CORE_IO_CYCLE_N_N(core_io_cycle_n_n),
      .CORE_RD_N(core_rd_n), .CORE_WR_N(core_wr_n), .CORE_M1_N(core_m1_n),
      .DATA_I(data_i), .ADDR_O(addr_o), .ADDR_OE(addr_oe), .DATA_O(data_o),
      .DATA_OE(data_oe), .MEMORY_CYCLE_N(mem_n), .IO_CYCLE_N(io_n),
      .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .STROBE_OE(strobe_oe),
      .OPCODE_FETCH_CYCLE_N(m1_n), .BUS_HOLD_GRANT_N(grant_n),
      .CPU_RESET_N(cpu_reset_n), .CORE_STALL(core_stall), .SVC_REQ(svc_req),
      .SVC_NMI(svc_nmi), .SVC_VECTOR(svc_vector), .SVC_DATA(svc_data));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   task automatic pulse_done;
      instr_done = 1'b1;
      mcycle_end = 1'b1;
      cyc(1);
      instr_done = 1'b0;
      mcycle_end = 1'b0;
   endtask : pulse_done

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk("cpu_reset_n", 16'h0, cpu_reset_n);
      chk("stall", 16'h1, core_stall);
      chk("grant_n", 16'h1, grant_n);
      chk("svc_req", 16'h0, svc_req);
      cyc(1);
      rst_n = 1'b1;
      cyc(6);
      chk("cpu_reset_n", 16'h1, cpu_reset_n);
      chk("addr_o", core_addr, addr_o);
      chk("addr_oe", 16'h1, addr_oe);
      chk("data_o", {8'h0, core_dout}, {8'h0, data_o});
      chk("data_oe", 16'h1, data_oe);
      chk("mem_n", 16'h0, mem_n);
      chk("rd_n", 16'h0, rd_n);
      chk("wr_n", 16'h1, wr_n);
      $display("test reset done");
   endtask : t_reset

   task automatic t_nmi;
      irq_enable = 1'b0;
      want_nmi = 1'b1;
      cyc(7);
      pulse_done();
      chk("svc_req", 16'h1, svc_req);
      chk("svc_nmi", 16'h1, svc_nmi);
      chk("svc_vector", 16'h0066, svc_vector);
      cyc(1);
      chk("svc_req", 16'h0, svc_req);
      want_nmi = 1'b0;
      cyc(7);
      $display("test nmi done");
   endtask : t_nmi

   task automatic t_irq(input logic [1:0] mode);
      logic [15:0] exp;
      irq_mode = mode;
      vb = 8'ha0 | {6'h0, mode};
      exp = (mode == 2'h1) ? 16'h0038 : (mode == 2'h2) ? {irq_page, vb} : 16'h0000;
      irq_enable = 1'b1;
      want_irq = 1'b1;
      cyc(7);
      pulse_done();
      chk("io_n", 16'h0, io_n);
      chk("m1_n", 16'h0, m1_n);
      chk("data_oe", 16'h0, data_oe);
      chk("mem_n", 16'h1, mem_n);
      chk("rd_n", 16'h1, rd_n);
      chk("wr_n", 16'h1, wr_n);
      cyc(3);
      chk("svc_req", 16'h0, svc_req);
      cyc(1);
      chk("svc_req", 16'h1, svc_req);
      chk("svc_nmi", 16'h0, svc_nmi);
      chk("svc_vector", exp, svc_vector);
      chk("svc_data", {8'h0, vb}, {8'h0, svc_data});
      chk("io_n", 16'h1, io_n);
      chk("stall", 16'h0, core_stall);
      want_irq = 1'b0;
      cyc(7);
      $display("test irq mode %0d done", mode);
   endtask : t_irq

   task automatic t_irq_off;
      irq_enable = 1'b0;
      want_irq = 1'b1;
      cyc(7);
      pulse_done();
      chk("io_n", 16'h1, io_n);
      cyc(4);
      chk("svc_req", 16'h0, svc_req);
      want_irq = 1'b0;
      cyc(7);
      $display("test irq disabled done");
   endtask : t_irq_off

   task automatic t_both;
      irq_enable = 1'b1;
      irq_mode = 2'h1;
      want_irq = 1'b1;
      want_nmi = 1'b1;
      cyc(7);
      pulse_done();
      chk("svc_nmi", 16'h1, svc_nmi);
      chk("io_n", 16'h1, io_n);
      pulse_done();
      chk("io_n", 16'h0, io_n);
      cyc(4);
      chk("svc_req", 16'h1, svc_req);
      chk("svc_nmi", 16'h0, svc_nmi);
      want_irq = 1'b0;
      want_nmi = 1'b0;
      cyc(7);
      $display("test nmi over irq done");
   endtask : t_both

   task automatic t_hold;
      irq_enable = 1'b1;
      want_hold = 1'b1;
      want_nmi = 1'b1;
      want_irq = 1'b1;
      cyc(7);
      chk("grant_n", 16'h1, grant_n);
      pulse_done();
      chk("grant_n", 16'h0, grant_n);
      chk("addr_oe", 16'h0, addr_oe);
      chk("strobe_oe", 16'h0, strobe_oe);
      chk("data_oe", 16'h0, data_oe);
      chk("stall", 16'h1, core_stall);
      chk("svc_req", 16'h0, svc_req);
      pulse_done();
      chk("svc_req", 16'h0, svc_req);
      chk("io_n", 16'h1, io_n);
      want_irq = 1'b0;
      want_hold = 1'b0;
      cyc(4);
      chk("grant_n", 16'h0, grant_n);
      cyc(3);
      chk("grant_n", 16'h1, grant_n);
      chk("addr_oe", 16'h1, addr_oe);
      chk("strobe_oe", 16'h1, strobe_oe);
      chk("stall", 16'h0, core_stall);
      pulse_done();
      chk("svc_req", 16'h1, svc_req);
      chk("svc_nmi", 16'h1, svc_nmi);
      want_nmi = 1'b0;
      cyc(7);
      $display("test hold done");
   endtask : t_hold

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      cyc(4);
      t_reset();
      t_nmi();
      for (int m = 0; m < 4; m++)
         t_irq(m[1:0]);
      t_irq_off();
      t_both();
      t_hold();
      finish_test();
   end

   initial
   begin
      #20000;
      fail_count++;
      finish_test();
   end
endmodule : tb_top
